// *** hw/eeip_pkg.sv ***
package eeip_pkg;

  // ----------------------------------------
  // Status register layout
  // ----------------------------------------
  localparam logic [31:0] STATUS_ADDR = 32'h0000_0500;
  localparam int LOCK_BIT = 0;
  localparam int THR_LSB = 16;
  localparam int THR_MSB = 23;
  localparam logic [63:0] STATUS_RESET = 64'h0000_0000_0000_0000;

  // ----------------------------------------
  // Debug control bit positions
  // ----------------------------------------
  localparam int DBGCTL_TXN_BIT = 15;
  localparam int DR7_TXN_BIT = 11;
  localparam int DR6_TXN_BIT = 16;
  localparam int PEND_TXN_BIT = 16;

  // ----------------------------------------
  // Counts of cycles
  // ----------------------------------------
  localparam logic [3:0] FLUSH_CYCLES = 4'h1;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0] {
    EEIP_ACT_NONE,
    EEIP_ACT_RESTART,
    EEIP_ACT_FALLBACK,
    EEIP_ACT_FALLBACK_GP,
    EEIP_ACT_DEBUG_EXIT
  } eeip_txn_act_t;

  typedef struct packed {
    logic leaf_in_enclave;
    logic entry_event;
    logic exit_start;
    logic exit_done;
  } eeip_launch_ev_t;

  typedef struct packed {
    logic in_elision;
    logic in_restricted;
    logic enclave_insn;
    logic fetch_outside;
    logic map_denied;
    logic abort;
    logic fallback_outside;
    logic debug_event;
    logic breakpoint_event;
    logic causes_vm_exit;
  } eeip_txn_ev_t;

endpackage

// *** hw/eeip_txn_policy.sv ***
`timescale 1ns/100ps
module eeip_txn_policy (
  // Clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Event inputs
  input wire eeip_pkg::eeip_txn_ev_t ev_in,
  input wire logic in_enclave_in,
  input wire logic opt_in_in,
  input wire logic dr7_txn_en_in,
  input wire logic dbgctl_txn_en_in,
  // Decisions
  output eeip_pkg::eeip_txn_act_t act_out,
  output logic gp_fault_out,
  output logic dr6_clear_out,
  output logic pend_dbg_set_out
);

  logic txn;
  logic dbg_full;
  eeip_pkg::eeip_txn_act_t act_d;

  assign txn = ev_in.in_restricted;
  assign dbg_full = opt_in_in & dr7_txn_en_in & dbgctl_txn_en_in;

  always_comb begin
    act_d = eeip_pkg::EEIP_ACT_NONE;
    if (ev_in.enclave_insn & ev_in.in_elision) begin
      act_d = eeip_pkg::EEIP_ACT_RESTART;
    end else if (in_enclave_in & txn) begin
      if ((ev_in.debug_event | ev_in.breakpoint_event) & dbg_full) begin
        act_d = eeip_pkg::EEIP_ACT_DEBUG_EXIT;
      end else if (ev_in.enclave_insn | ev_in.fetch_outside | ev_in.map_denied |
                   ev_in.abort | ev_in.debug_event | ev_in.breakpoint_event) begin
        act_d = ev_in.fallback_outside ? eeip_pkg::EEIP_ACT_FALLBACK_GP :
                                         eeip_pkg::EEIP_ACT_FALLBACK;
      end
    end else if (txn & ev_in.enclave_insn) begin
      act_d = eeip_pkg::EEIP_ACT_FALLBACK;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      act_out <= eeip_pkg::EEIP_ACT_NONE;
      gp_fault_out <= 1'b0;
      dr6_clear_out <= 1'b0;
      pend_dbg_set_out <= 1'b0;
    end else begin
      act_out <= act_d;
      gp_fault_out <= (act_d == eeip_pkg::EEIP_ACT_FALLBACK_GP);
      dr6_clear_out <= (act_d == eeip_pkg::EEIP_ACT_DEBUG_EXIT) & ~ev_in.causes_vm_exit;
      pend_dbg_set_out <= (act_d == eeip_pkg::EEIP_ACT_DEBUG_EXIT) & ev_in.causes_vm_exit;
    end
  end

endmodule

// *** hw/eeip_policy.sv ***
`timescale 1ns/100ps
module eeip_policy #(
  parameter int BANKS = 8,
  parameter int BANK_BITS = 64
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Capabilities and firmware setup
  input wire logic safer_mode_capability_in,
  input wire logic feature_enabled_in,
  input wire logic [7:0] fw_threshold_in,
  input wire logic fw_threshold_we_in,
  // Bank enables, as supported mask and current value
  input wire logic [BANKS*BANK_BITS-1:0] bank_supported_in,
  input wire logic [BANKS*BANK_BITS-1:0] bank_enables_in,
  // Enclave state and entry
  input wire logic in_enclave_in,
  input wire logic enclave_entry_in,
  input wire logic enclave_exit_in,
  input wire logic debug_opt_in_flag_in,
  input wire logic enclave_insn_ok_in,
  // Measured launch events
  input wire eeip_pkg::eeip_launch_ev_t launch_in,
  input wire logic launch_module_in,
  input wire logic [7:0] module_version_in,
  // Transaction events and debug enables
  input wire eeip_pkg::eeip_txn_ev_t txn_in,
  input wire logic [31:0] dr7_in,
  input wire logic [31:0] dbgctl_in,
  // Machine check events
  input wire logic machine_check_in,
  input wire logic corrected_error_in,
  // Status register read port
  input wire logic rd_en_in,
  input wire logic [31:0] rd_addr_in,
  output logic [63:0] rd_data_out,
  output logic rd_hit_out,
  // Decisions
  output logic invalid_opcode_fault_out,
  output logic async_exit_out,
  output logic wait_startup_out,
  output logic paused_out,
  output logic launch_shutdown_out,
  output logic launch_allow_out,
  output logic flush_out,
  output logic monitor_clear_out,
  output logic feature_available_out,
  output eeip_pkg::eeip_txn_act_t txn_act_out,
  output logic gp_fault_out,
  output logic dr6_clear_out,
  output logic pend_dbg_set_out,
  output logic opt_in_out
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef enum {
    EEIP_RUN,
    EEIP_WAIT_STARTUP,
    EEIP_PAUSED
  } eeip_rlp_t;

  eeip_rlp_t rlp_q;
  logic lock_q;
  logic [7:0] thr_q;
  logic opt_in_q;
  logic was_enabled_q;
  logic mc_disabled_q;
  logic banks_ok;
  logic [BANKS*BANK_BITS-1:0] bank_prev_q;
  logic bank_dropped;
  logic [BANKS-1:0] bank_drop_each;
  logic [63:0] status;
  logic [3:0] flush_cnt_q;
  logic [3:0] monitor_cnt_q;

  function automatic logic all_set(input logic [BANKS*BANK_BITS-1:0] sup,
                                   input logic [BANKS*BANK_BITS-1:0] val);
    all_set = &(val | ~sup);
  endfunction

  function automatic logic status_hit(input logic en, input logic [31:0] addr);
    status_hit = en & (addr == eeip_pkg::STATUS_ADDR);
  endfunction

  // Lock read live, so a freshly set lock applies at once
  function automatic logic version_blocked(input logic lock, input logic [7:0] ver,
                                           input logic [7:0] thr);
    version_blocked = lock & (ver < thr);
  endfunction

  // ----------------------------------------
  // Measured launch handling
  // ----------------------------------------
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      invalid_opcode_fault_out <= 1'b0;
    end else begin
      invalid_opcode_fault_out <= launch_in.leaf_in_enclave & in_enclave_in;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rlp_q <= EEIP_RUN;
    end else begin
      unique case (rlp_q)
        EEIP_RUN: begin
          if (launch_in.entry_event & in_enclave_in) begin
            rlp_q <= EEIP_WAIT_STARTUP;
          end else if (launch_in.exit_start & in_enclave_in & ~launch_in.exit_done) begin
            rlp_q <= EEIP_PAUSED;
          end
        end
        EEIP_WAIT_STARTUP: begin
          if (enclave_entry_in) begin
            rlp_q <= EEIP_RUN;
          end
        end
        EEIP_PAUSED: begin
          if (launch_in.exit_done) begin
            rlp_q <= EEIP_RUN;
          end
        end
      endcase
    end
  end

  assign wait_startup_out = (rlp_q == EEIP_WAIT_STARTUP);
  assign paused_out = (rlp_q == EEIP_PAUSED);

  // ----------------------------------------
  // Version lock and threshold
  // ----------------------------------------
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      lock_q <= eeip_pkg::STATUS_RESET[eeip_pkg::LOCK_BIT];
    end else if (enclave_insn_ok_in) begin
      lock_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      thr_q <= eeip_pkg::STATUS_RESET[eeip_pkg::THR_MSB:eeip_pkg::THR_LSB];
    end else if (fw_threshold_we_in & ~lock_q) begin
      thr_q <= fw_threshold_in;
    end
  end

  // Decided at launch time against the live lock
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      launch_shutdown_out <= 1'b0;
      launch_allow_out <= 1'b0;
    end else begin
      launch_shutdown_out <= launch_module_in & version_blocked(lock_q, module_version_in, thr_q);
      launch_allow_out <= launch_module_in & ~version_blocked(lock_q, module_version_in, thr_q);
    end
  end

  // ----------------------------------------
  // Status register read
  // ----------------------------------------
  always_comb begin
    status = 64'h0000_0000_0000_0000;
    status[eeip_pkg::LOCK_BIT] = lock_q;
    if (safer_mode_capability_in) begin
      status[eeip_pkg::THR_MSB:eeip_pkg::THR_LSB] = thr_q;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rd_data_out <= 64'h0000_0000_0000_0000;
      rd_hit_out <= 1'b0;
    end else begin
      rd_hit_out <= status_hit(rd_en_in, rd_addr_in);
      rd_data_out <= status_hit(rd_en_in, rd_addr_in) ? status : 64'h0000_0000_0000_0000;
    end
  end

  // ----------------------------------------
  // Translation flush on entry and exit
  // ----------------------------------------
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      flush_cnt_q <= 4'h0;
    end else if (enclave_entry_in | enclave_exit_in | async_exit_out) begin
      flush_cnt_q <= eeip_pkg::FLUSH_CYCLES;
    end else if (flush_cnt_q != 4'h0) begin
      flush_cnt_q <= flush_cnt_q - 4'h1;
    end
  end

  assign flush_out = (flush_cnt_q != 4'h0);

  // ----------------------------------------
  // Address monitor clear on entry and exit
  // ----------------------------------------
  // Own counter, loaded with FLUSH_CYCLES on the same events, so monitor timing matches the flush
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      monitor_cnt_q <= 4'h0;
    end else if (enclave_entry_in | enclave_exit_in | async_exit_out) begin
      monitor_cnt_q <= eeip_pkg::FLUSH_CYCLES;
    end else if (monitor_cnt_q != 4'h0) begin
      monitor_cnt_q <= monitor_cnt_q - 4'h1;
    end
  end

  assign monitor_clear_out = (monitor_cnt_q != 4'h0);

  // ----------------------------------------
  // Debug opt-in capture
  // ----------------------------------------
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      opt_in_q <= 1'b0;
    end else if (enclave_entry_in) begin
      opt_in_q <= debug_opt_in_flag_in;
    end
  end

  assign opt_in_out = opt_in_q;

  eeip_txn_policy u_txn (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .ev_in(txn_in),
    .in_enclave_in(in_enclave_in),
    .opt_in_in(opt_in_q),
    .dr7_txn_en_in(dr7_in[eeip_pkg::DR7_TXN_BIT]),
    .dbgctl_txn_en_in(dbgctl_in[eeip_pkg::DBGCTL_TXN_BIT]),
    .act_out(txn_act_out),
    .gp_fault_out(gp_fault_out),
    .dr6_clear_out(dr6_clear_out),
    .pend_dbg_set_out(pend_dbg_set_out)
  );

  // ----------------------------------------
  // Asynchronous exit causes
  // ----------------------------------------
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      async_exit_out <= 1'b0;
    end else begin
      async_exit_out <= in_enclave_in &
                        (machine_check_in | corrected_error_in | launch_in.entry_event |
                         (txn_act_out == eeip_pkg::EEIP_ACT_DEBUG_EXIT));
    end
  end

  // ----------------------------------------
  // Feature availability
  // ----------------------------------------
  assign banks_ok = all_set(bank_supported_in, bank_enables_in);
  // Per-bank reduction keeps each tree small
  for (genvar b = 0; b < BANKS; b++) begin : g_bank_drop
    assign bank_drop_each[b] = |(bank_prev_q[b*BANK_BITS +: BANK_BITS] &
                                 ~bank_enables_in[b*BANK_BITS +: BANK_BITS] &
                                 bank_supported_in[b*BANK_BITS +: BANK_BITS]);
  end

  assign bank_dropped = |bank_drop_each;

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      bank_prev_q <= '0;
    end else begin
      bank_prev_q <= bank_enables_in;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      was_enabled_q <= 1'b0;
    end else if (feature_enabled_in) begin
      was_enabled_q <= 1'b1;
    end
  end

  // Sticky until reset; no software path can clear it
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      mc_disabled_q <= 1'b0;
    end else if (machine_check_in & (was_enabled_q | feature_enabled_in)) begin
      mc_disabled_q <= 1'b1;
    end else if (bank_dropped) begin
      mc_disabled_q <= 1'b1;
    end
  end

  assign feature_available_out = banks_ok & ~mc_disabled_q;

endmodule

// *** tb/eeip_policy_chk.sv ***
`timescale 1ns/100ps
module eeip_policy_chk (
  // Clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Watched inputs
  input wire eeip_pkg::eeip_launch_ev_t launch_in,
  input wire eeip_pkg::eeip_txn_ev_t txn_in,
  input wire logic in_enclave_in,
  input wire logic enclave_entry_in,
  input wire logic enclave_exit_in,
  input wire logic feature_enabled_in,
  input wire logic machine_check_in,
  input wire logic corrected_error_in,
  input wire logic rd_en_in,
  input wire logic [31:0] rd_addr_in,
  // Watched outputs
  input wire logic [63:0] rd_data_out,
  input wire logic rd_hit_out,
  input wire logic invalid_opcode_fault_out,
  input wire logic async_exit_out,
  input wire logic wait_startup_out,
  input wire logic paused_out,
  input wire logic flush_out,
  input wire logic monitor_clear_out,
  input wire logic feature_available_out,
  input wire eeip_pkg::eeip_txn_act_t txn_act_out,
  input wire logic gp_fault_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  // ----------------------------------------
  // Sequences
  // ----------------------------------------
  sequence s_rd_req;
    rd_en_in && rd_addr_in == eeip_pkg::STATUS_ADDR;
  endsequence
  sequence s_exit_wait;
    async_exit_out && wait_startup_out;
  endsequence
  sequence s_fallback;
    txn_act_out == eeip_pkg::EEIP_ACT_FALLBACK && !gp_fault_out;
  endsequence
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  AST_UD: assert property (launch_in.leaf_in_enclave && in_enclave_in |=> invalid_opcode_fault_out)
    else $error("invalid opcode fault missing");
  AST_RESP: assert property (launch_in.entry_event && in_enclave_in |=> s_exit_wait)
    else $error("responder did not exit and wait");
  AST_PAUSE: assert property (launch_in.exit_start && !launch_in.exit_done && in_enclave_in
    && !paused_out && !wait_startup_out |=> paused_out)
    else $error("responder not paused");
  AST_UNPAUSE: assert property (paused_out && launch_in.exit_done |=> !paused_out)
    else $error("responder still paused");
  AST_RD_HIT: assert property (s_rd_req |=> rd_hit_out)
    else $error("status read not answered");
  AST_RD_MISS: assert property (rd_en_in && rd_addr_in != eeip_pkg::STATUS_ADDR
    |=> !rd_hit_out && rd_data_out == 64'h0)
    else $error("other address answered");
  AST_RSVD: assert property (rd_hit_out |-> rd_data_out[63:24] == 40'h0
    && rd_data_out[15:1] == 15'h0)
    else $error("reserved status bits set");
  AST_FLUSH: assert property (enclave_entry_in || enclave_exit_in |=> flush_out && monitor_clear_out)
    else $error("flush missing");
  AST_MC_EXIT: assert property ((machine_check_in || corrected_error_in) && in_enclave_in
    |=> async_exit_out)
    else $error("machine check exit missing");
  AST_MC_OFF: assert property (machine_check_in && feature_enabled_in |=> !feature_available_out [*3])
    else $error("feature not disabled");
  AST_FETCH: assert property (in_enclave_in && txn_in.in_restricted && txn_in.fetch_outside
    && !txn_in.fallback_outside && !txn_in.in_elision && !txn_in.debug_event
    && !txn_in.breakpoint_event |=> s_fallback)
    else $error("outside fetch not sent to fallback");
endmodule
bind eeip_policy eeip_policy_chk eeip_policy_chk_i (.*);

// *** tb/eeip_policy_bench.sv ***
`timescale 1ns/100ps
module eeip_policy_bench;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic safer_mode_capability_in = 1'b1;
  logic feature_enabled_in = 1'b0;
  logic [7:0] fw_threshold_in = 8'h00;
  logic fw_threshold_we_in = 1'b0;
  logic [511:0] bank_supported_in = '1;
  logic [511:0] bank_enables_in = '1;
  logic in_enclave_in = 1'b0, enclave_entry_in = 1'b0, enclave_exit_in = 1'b0;
  logic debug_opt_in_flag_in = 1'b0, enclave_insn_ok_in = 1'b0, launch_module_in = 1'b0;
  eeip_pkg::eeip_launch_ev_t launch_in = '0;
  logic [7:0] module_version_in = 8'h00;
  eeip_pkg::eeip_txn_ev_t txn_in = '0;
  logic [31:0] dr7_in = 32'h0000_0000, dbgctl_in = 32'h0000_0000, rd_addr_in = 32'h0000_0000;
  logic machine_check_in = 1'b0, corrected_error_in = 1'b0, rd_en_in = 1'b0;
  logic [63:0] rd_data_out;
  logic rd_hit_out, invalid_opcode_fault_out, async_exit_out, wait_startup_out, paused_out;
  logic launch_shutdown_out, launch_allow_out, flush_out, monitor_clear_out;
  logic feature_available_out, gp_fault_out, dr6_clear_out, pend_dbg_set_out, opt_in_out;
  eeip_pkg::eeip_txn_act_t txn_act_out;
  int fails = 0, n_compared = 0;
  eeip_policy eeip_policy_i (.*);
  always #2.5 clk_in = ~clk_in;
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    if (fails == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic do_reset();
    sys_rst_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    sys_rst_in <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [63:0] e);
    @(posedge clk_in);
    rd_en_in <= 1'b1;
    rd_addr_in <= a;
    @(posedge clk_in);
    rd_en_in <= 1'b0;
    #1;
    cmp({63'h0, rd_hit_out}, {63'h0, a == eeip_pkg::STATUS_ADDR});
    cmp(rd_data_out, e);
  endtask
  task automatic launch(input logic [7:0] v, input logic sd);
    @(posedge clk_in);
    launch_module_in <= 1'b1;
    module_version_in <= v;
    @(posedge clk_in);
    launch_module_in <= 1'b0;
    #1;
    cmp({63'h0, launch_shutdown_out}, {63'h0, sd});
    cmp({63'h0, launch_allow_out}, {63'h0, !sd});
  endtask
  task automatic lev(input eeip_pkg::eeip_launch_ev_t v);
    @(posedge clk_in);
    launch_in <= v;
    @(posedge clk_in);
    launch_in <= '0;
    #1;
  endtask
  task automatic ent(input logic f);
    @(posedge clk_in);
    enclave_entry_in <= 1'b1;
    debug_opt_in_flag_in <= f;
    @(posedge clk_in);
    enclave_entry_in <= 1'b0;
    #1;
    cmp({63'h0, opt_in_out}, {63'h0, f});
  endtask
  task automatic txn(input logic [9:0] ev, input eeip_pkg::eeip_txn_act_t act, input logic gp);
    @(posedge clk_in);
    txn_in <= ev;
    @(posedge clk_in);
    txn_in <= '0;
    #1;
    cmp({61'h0, txn_act_out}, {61'h0, act});
    cmp({63'h0, gp_fault_out}, {63'h0, gp});
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_lock();
    @(posedge clk_in);
    fw_threshold_in <= 8'h5a;
    fw_threshold_we_in <= 1'b1;
    @(posedge clk_in);
    fw_threshold_we_in <= 1'b0;
    rd(32'h0000_0500, 64'h0000_0000_005a_0000);
    rd(32'h0000_0501, 64'h0);
    launch(8'h10, 1'b0);
    @(posedge clk_in);
    enclave_insn_ok_in <= 1'b1;
    fw_threshold_in <= 8'h33;
    @(posedge clk_in);
    enclave_insn_ok_in <= 1'b0;
    fw_threshold_we_in <= 1'b1;
    @(posedge clk_in);
    fw_threshold_we_in <= 1'b0;
    rd(32'h0000_0500, 64'h0000_0000_005a_0001);
    launch(8'h59, 1'b1);
    launch(8'h5a, 1'b0);
    launch(8'h5b, 1'b0);
    launch(8'h40, 1'b1);
    rd(32'h0000_0500, 64'h0000_0000_005a_0001);
    @(posedge clk_in);
    safer_mode_capability_in <= 1'b0;
    rd(32'h0000_0500, 64'h0000_0000_0000_0001);
    safer_mode_capability_in <= 1'b1;
  endtask
  task automatic t_resp();
    @(posedge clk_in);
    in_enclave_in <= 1'b1;
    lev(4'b1000);
    cmp({63'h0, invalid_opcode_fault_out}, 64'h1);
    lev(4'b0100);
    cmp({63'h0, async_exit_out}, 64'h1);
    cmp({63'h0, wait_startup_out}, 64'h1);
    ent(1'b0);
    cmp({63'h0, flush_out & monitor_clear_out}, 64'h1);
    lev(4'b0010);
    lev(4'b0000);
    cmp({63'h0, paused_out}, 64'h1);
    lev(4'b0001);
    cmp({63'h0, paused_out}, 64'h0);
  endtask
  // Enclave stays entered; debug enables are set one case before opt-in, so that debug event still falls back
  task automatic t_txn();
    txn(10'b10_1000_0000, eeip_pkg::EEIP_ACT_RESTART, 1'b0);
    txn(10'b01_1000_0000, eeip_pkg::EEIP_ACT_FALLBACK, 1'b0);
    txn(10'b01_0100_0000, eeip_pkg::EEIP_ACT_FALLBACK, 1'b0);
    txn(10'b01_0010_0000, eeip_pkg::EEIP_ACT_FALLBACK, 1'b0);
    txn(10'b01_0001_1000, eeip_pkg::EEIP_ACT_FALLBACK_GP, 1'b1);
    dr7_in <= 32'h0000_0800;
    dbgctl_in <= 32'h0000_8000;
    txn(10'b01_0000_0100, eeip_pkg::EEIP_ACT_FALLBACK, 1'b0);
    ent(1'b1);
    txn(10'b01_0000_0010, eeip_pkg::EEIP_ACT_DEBUG_EXIT, 1'b0);
    cmp({63'h0, dr6_clear_out}, 64'h1);
    txn(10'b01_0000_0101, eeip_pkg::EEIP_ACT_DEBUG_EXIT, 1'b0);
    cmp({62'h0, pend_dbg_set_out, dr6_clear_out}, 64'h2);
    dr7_in <= 32'h0000_0000;
    txn(10'b01_0000_0100, eeip_pkg::EEIP_ACT_FALLBACK, 1'b0);
  endtask
  task automatic t_mc();
    @(posedge clk_in);
    feature_enabled_in <= 1'b1;
    bank_enables_in[7] <= 1'b0;
    @(posedge clk_in);
    bank_enables_in[7] <= 1'b1;
    repeat (2) @(posedge clk_in);
    #1;
    cmp({63'h0, feature_available_out}, 64'h0);
    do_reset();
    @(posedge clk_in);
    #1;
    cmp({63'h0, feature_available_out}, 64'h1);
    @(posedge clk_in);
    machine_check_in <= 1'b1;
    @(posedge clk_in);
    machine_check_in <= 1'b0;
    #1;
    cmp({63'h0, async_exit_out}, 64'h1);
    repeat (3) @(posedge clk_in);
    #1;
    cmp({63'h0, feature_available_out}, 64'h0);
    @(posedge clk_in);
    corrected_error_in <= 1'b1;
    @(posedge clk_in);
    corrected_error_in <= 1'b0;
    #1;
    cmp({63'h0, async_exit_out}, 64'h1);
  endtask
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    do_reset();
    t_lock();
    t_resp();
    t_txn();
    t_mc();
    summarize();
  end
  initial begin
    #100000;
    fails++;
    summarize();
  end
endmodule
